// File: pkg/scfg_pkg.sv
// scfg_pkg: register map, field positions, timing and types of the
// strap configuration and serial prom access block.
// assumes a 100 MHz core clock and a 16-bit register port.
`default_nettype none

package scfg_pkg;

  // register offsets, byte addresses on the register port
  localparam logic [7:0]  OFS_STRAP_CFG   = 8'h08;
  localparam logic [7:0]  OFS_ADDR_LOW    = 8'h10;
  localparam logic [7:0]  OFS_ADDR_MID    = 8'h12;
  localparam logic [7:0]  OFS_ADDR_HIGH   = 8'h14;
  localparam logic [7:0]  OFS_BUS_CLK     = 8'h20;
  localparam logic [7:0]  OFS_PROM_CTL    = 8'h22;

  // chip_strap_config field positions
  localparam int unsigned CFG_ENDIAN_BIT  = 10;
  localparam int unsigned CFG_PROM_BIT    = 9;
  localparam int unsigned CFG_BUS8_BIT    = 7;
  localparam int unsigned CFG_BUS16_BIT   = 6;
  localparam int unsigned CFG_SHARED_BIT  = 4;
  localparam int unsigned CFG_PKG48_BIT   = 1;

  // internal_bus_clock_control fields and reset value, and the station address reset value
  localparam int unsigned BUSCTL_DRIVE_BIT = 6;
  localparam int unsigned BUSCTL_DIV_LSB   = 0;
  localparam logic [15:0] BUSCTL_RESET     = 16'h0000;
  localparam logic [15:0] STATION_RESET    = 16'h0000;

  // serial_prom_control field positions
  localparam int unsigned PCTL_DIR_BIT    = 5;
  localparam int unsigned PCTL_EN_BIT     = 4;
  localparam int unsigned PCTL_DIN_BIT    = 3;
  localparam int unsigned PCTL_DOUT_BIT   = 2;
  localparam int unsigned PCTL_SCK_BIT    = 1;
  localparam int unsigned PCTL_CS_BIT     = 0;

  // three-wire read frame: start bit, opcode, 6-bit word address,
  // one dummy zero, then 16 data bits
  localparam logic [2:0]  PROM_READ_OP    = 3'h6;
  localparam logic [5:0]  PROM_FIRST_WORD = 6'h01;
  localparam logic [1:0]  PROM_LAST_IDX   = 2'h2;
  localparam logic [4:0]  PROM_HDR_BITS   = 5'h09;
  localparam logic [4:0]  PROM_LAST_BIT   = 5'h19;

  // serial clock half period, a least time, rounded up
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned PROM_HALF_NS    = 250;
  localparam int unsigned PROM_HALF_CYC   = (PROM_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  PROM_HALF_LAST  = 8'(PROM_HALF_CYC - 1);

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } scfg_bus_req_t;

  typedef struct packed {
    logic dir;
    logic en;
    logic dout;
    logic sck;
    logic cs;
  } scfg_prom_ctl_t;

  typedef enum logic [3:0] {
    ST_STRAP = 4'b0001,
    ST_SHIFT = 4'b0010,
    ST_GAP   = 4'b0100,
    ST_IDLE  = 4'b1000
  } scfg_state_t;

endpackage : scfg_pkg

`default_nettype wire

// File: rtl/scfg_top.sv
// scfg_top: strap capture, station address auto-load from a serial
// prom, bus clock / pad settings and bit-level prom pin access.
// assumes a synchronous register port and pins already synchronous.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module scfg_top (
  input  wire logic                   i_clock,
  input  wire logic                   i_rst,
  input  wire scfg_pkg::scfg_bus_req_t i_bus,
  output logic [15:0]                 o_rdata,
  input  wire logic                   i_port_led_strap_pin,
  input  wire logic                   i_shared_bus_strap,
  input  wire logic                   i_package_48pin_bond,
  input  wire logic                   i_prom_data_pin,
  output logic                        o_prom_data_pin,
  output logic                        o_prom_data_oe,
  input  wire logic                   i_prom_serial_clock_pin,
  output logic                        o_prom_serial_clock_pin,
  output logic                        o_prom_serial_clock_oe,
  output logic                        o_prom_chip_select_pin,
  output logic                        o_autoload_busy,
  output logic                        o_drive_strength_16ma,
  output logic [1:0]                  o_bus_clock_div
);

  scfg_pkg::scfg_state_t    state;
  scfg_pkg::scfg_prom_ctl_t ctl;
  logic [15:0]              cfg;
  logic [15:0]              station [3];
  logic [15:0]              bus_ctl;
  logic [7:0]               timer;
  logic                     sk_hi;
  logic [4:0]               bit_cnt;
  logic [1:0]               word_idx;
  logic [8:0]               out_sh;
  logic [15:0]              in_sh;
  logic                     half_done;
  logic                     load_store;
  logic                     next_cs;
  logic                     next_sk;
  logic                     next_sk_oe;
  logic                     next_dout;
  logic                     next_doe;

  // maps a port address onto a station register index, 3 when no match
  function automatic logic [1:0] station_index(input logic [7:0] addr);
    case (addr)
      scfg_pkg::OFS_ADDR_LOW:  station_index = 2'h0;
      scfg_pkg::OFS_ADDR_MID:  station_index = 2'h1;
      scfg_pkg::OFS_ADDR_HIGH: station_index = 2'h2;
      default:                 station_index = 2'h3;
    endcase
  endfunction : station_index

  // read frame header for a given station word
  function automatic logic [8:0] read_header(input logic [1:0] idx);
    read_header = {scfg_pkg::PROM_READ_OP, 6'(scfg_pkg::PROM_FIRST_WORD + 6'(idx))};
  endfunction : read_header

  assign half_done  = (timer == scfg_pkg::PROM_HALF_LAST);
  // last data bit was sampled on the final rising edge; store on the falling one
  assign load_store = (state == scfg_pkg::ST_SHIFT) && half_done && sk_hi
                      && (bit_cnt == scfg_pkg::PROM_LAST_BIT);

  // straps are caught one edge after reset release, pins still released
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cfg <= 16'h0000;
    end else if (state == scfg_pkg::ST_STRAP) begin
      cfg                           <= 16'h0000;
      cfg[scfg_pkg::CFG_ENDIAN_BIT] <= i_prom_serial_clock_pin;
      cfg[scfg_pkg::CFG_PROM_BIT]   <= i_prom_data_pin;
      cfg[scfg_pkg::CFG_BUS8_BIT]   <= i_port_led_strap_pin;
      cfg[scfg_pkg::CFG_BUS16_BIT]  <= ~i_port_led_strap_pin;
      cfg[scfg_pkg::CFG_SHARED_BIT] <= i_shared_bus_strap;
      cfg[scfg_pkg::CFG_PKG48_BIT]  <= i_package_48pin_bond;
    end
  end

  // auto-load sequencer
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state <= scfg_pkg::ST_STRAP;
    end else begin
      unique case (state)
        scfg_pkg::ST_STRAP: begin
          state <= i_prom_data_pin ? scfg_pkg::ST_SHIFT : scfg_pkg::ST_IDLE;
        end
        scfg_pkg::ST_SHIFT: begin
          if (load_store) begin
            state <= scfg_pkg::ST_GAP;
          end
        end
        scfg_pkg::ST_GAP: begin
          if (half_done) begin
            state <= (word_idx == scfg_pkg::PROM_LAST_IDX) ? scfg_pkg::ST_IDLE
                                                           : scfg_pkg::ST_SHIFT;
          end
        end
        scfg_pkg::ST_IDLE: begin
          state <= scfg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      timer <= 8'h00;
    end else if (state == scfg_pkg::ST_SHIFT || state == scfg_pkg::ST_GAP) begin
      timer <= half_done ? 8'h00 : 8'(timer + 8'h01);
    end else begin
      timer <= 8'h00;
    end
  end

  // serial clock phase and bit position within a frame
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sk_hi   <= 1'b0;
      bit_cnt <= 5'h00;
    end else if (state == scfg_pkg::ST_SHIFT) begin
      if (half_done) begin
        sk_hi <= ~sk_hi;
        if (sk_hi) begin
          bit_cnt <= 5'(bit_cnt + 5'h01);
        end
      end
    end else begin
      sk_hi   <= 1'b0;
      bit_cnt <= 5'h00;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      word_idx <= 2'h0;
    end else if (state == scfg_pkg::ST_GAP && half_done) begin
      word_idx <= 2'(word_idx + 2'h1);
    end
  end

  // command shifts out msb first, changing only while the clock is low
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      out_sh <= 9'h000;
    end else if (state == scfg_pkg::ST_STRAP) begin
      out_sh <= read_header(2'h0);
    end else if (state == scfg_pkg::ST_GAP && half_done) begin
      out_sh <= read_header(2'(word_idx + 2'h1));
    end else if (state == scfg_pkg::ST_SHIFT && half_done && sk_hi) begin
      out_sh <= {out_sh[7:0], 1'b0};
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      in_sh <= 16'h0000;
    end else if (state == scfg_pkg::ST_SHIFT && half_done && !sk_hi) begin
      in_sh <= {in_sh[14:0], i_prom_data_pin};
    end
  end

  // a finished prom word beats a software write to the same register
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 3; i++) begin
        station[i] <= scfg_pkg::STATION_RESET;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (load_store && word_idx == 2'(i)) begin
          station[i] <= in_sh;
        end else if (i_bus.wr && station_index(i_bus.addr) == 2'(i)) begin
          station[i] <= i_bus.wdata;
        end
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      bus_ctl <= scfg_pkg::BUSCTL_RESET;
    end else if (i_bus.wr && i_bus.addr == scfg_pkg::OFS_BUS_CLK) begin
      bus_ctl <= i_bus.wdata;
    end
  end

  assign o_drive_strength_16ma = bus_ctl[scfg_pkg::BUSCTL_DRIVE_BIT];
  assign o_bus_clock_div = bus_ctl[scfg_pkg::BUSCTL_DIV_LSB +: 2];

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ctl <= '0;
    end else if (i_bus.wr && i_bus.addr == scfg_pkg::OFS_PROM_CTL) begin
      ctl.dir  <= i_bus.wdata[scfg_pkg::PCTL_DIR_BIT];
      ctl.en   <= i_bus.wdata[scfg_pkg::PCTL_EN_BIT];
      ctl.dout <= i_bus.wdata[scfg_pkg::PCTL_DOUT_BIT];
      ctl.sck  <= i_bus.wdata[scfg_pkg::PCTL_SCK_BIT];
      ctl.cs   <= i_bus.wdata[scfg_pkg::PCTL_CS_BIT];
    end
  end

  // read data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (i_bus.rd) begin
      o_rdata <= 16'h0000;
      case (i_bus.addr)
        scfg_pkg::OFS_STRAP_CFG: o_rdata <= cfg;
        scfg_pkg::OFS_ADDR_LOW,
        scfg_pkg::OFS_ADDR_MID,
        scfg_pkg::OFS_ADDR_HIGH: o_rdata <= station[station_index(i_bus.addr)];
        scfg_pkg::OFS_BUS_CLK:   o_rdata <= bus_ctl;
        scfg_pkg::OFS_PROM_CTL: begin
          o_rdata[scfg_pkg::PCTL_EN_BIT]   <= ctl.en;
          o_rdata[scfg_pkg::PCTL_DIN_BIT]  <= i_prom_data_pin;
          o_rdata[scfg_pkg::PCTL_DOUT_BIT] <= ctl.dout;
          o_rdata[scfg_pkg::PCTL_SCK_BIT]  <= ctl.sck;
          o_rdata[scfg_pkg::PCTL_CS_BIT]   <= ctl.cs;
        end
        default: o_rdata <= 16'h0000;
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  // pin owner: strap window releases all, auto-load, then software if enabled
  always_comb begin
    next_cs    = 1'b0;
    next_sk    = 1'b0;
    next_sk_oe = (state != scfg_pkg::ST_STRAP);
    next_dout  = 1'b0;
    next_doe   = 1'b0;
    if (state == scfg_pkg::ST_SHIFT) begin
      next_cs   = 1'b1;
      next_sk   = sk_hi;
      next_dout = out_sh[8];
      next_doe  = (bit_cnt < scfg_pkg::PROM_HDR_BITS);
    end else if (state == scfg_pkg::ST_IDLE && ctl.en) begin
      next_cs   = ctl.cs;
      next_sk   = ctl.sck;
      next_dout = ctl.dout;
      next_doe  = ctl.dir;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_prom_chip_select_pin  <= 1'b0;
      o_prom_serial_clock_pin <= 1'b0;
      o_prom_serial_clock_oe  <= 1'b0;
      o_prom_data_pin         <= 1'b0;
      o_prom_data_oe          <= 1'b0;
      o_autoload_busy         <= 1'b0;
    end else begin
      o_prom_chip_select_pin  <= next_cs;
      o_prom_serial_clock_pin <= next_sk;
      o_prom_serial_clock_oe  <= next_sk_oe;
      o_prom_data_pin         <= next_dout;
      o_prom_data_oe          <= next_doe;
      o_autoload_busy         <= (state == scfg_pkg::ST_SHIFT || state == scfg_pkg::ST_GAP);
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  chk_endian_strap_cap: assert property (
    (state == scfg_pkg::ST_STRAP) |=> (cfg[10] == $past(i_prom_serial_clock_pin))
  ) else $error("endian strap not captured");

  chk_prom_strap_cap: assert property (
    (state == scfg_pkg::ST_STRAP) |=> (cfg[9] == $past(i_prom_data_pin))
  ) else $error("prom presence strap not captured");

  chk_bus8_width_strap: assert property (
    (state == scfg_pkg::ST_STRAP) |=> (cfg[7] == $past(i_port_led_strap_pin))
  ) else $error("8-bit width strap wrong");

  chk_bus16_width_strap: assert property (
    (state != scfg_pkg::ST_STRAP) |-> (cfg[6] != cfg[7])
  ) else $error("16-bit width strap not complement of 8-bit");

  chk_shared_bus_strap: assert property (
    (state == scfg_pkg::ST_STRAP) |=> (cfg[4] == $past(i_shared_bus_strap))
  ) else $error("shared bus strap wrong");

  chk_cfg_reserved_zero: assert property (
    (state == scfg_pkg::ST_STRAP) ##1 1'b1 |-> ((cfg & 16'hF92D) == 16'h0000)
      && (cfg[1] == $past(i_package_48pin_bond))
  ) else $error("config reserved bits or package bit wrong");

  chk_autoload_start: assert property (
    (state == scfg_pkg::ST_STRAP && i_prom_data_pin) |=> (out_sh == 9'h181) ##1 o_autoload_busy
  ) else $error("auto-load did not start at word 1");

  chk_no_prom_idle: assert property (
    (state == scfg_pkg::ST_STRAP && !i_prom_data_pin) |=> (state == scfg_pkg::ST_IDLE)
  ) else $error("auto-load ran without a prom");

  chk_word_store_map: assert property (
    load_store |=> (station[$past(word_idx)] == $past(in_sh))
  ) else $error("prom word stored in wrong register");

  chk_station_sw_write: assert property (
    (i_bus.wr && i_bus.addr == scfg_pkg::OFS_ADDR_MID && !load_store)
      |=> (station[1] == $past(i_bus.wdata))
  ) else $error("station register write lost");

  chk_drive_strength_wr: assert property (
    (i_bus.wr && i_bus.addr == scfg_pkg::OFS_BUS_CLK)
      |=> (o_drive_strength_16ma == $past(i_bus.wdata[6]))
        && (o_bus_clock_div == $past(i_bus.wdata[1:0]))
  ) else $error("bus control write not applied");

  chk_sw_pin_follow: assert property (
    (state == scfg_pkg::ST_IDLE && ctl.en) |=> (o_prom_chip_select_pin == $past(ctl.cs))
      && (o_prom_serial_clock_pin == $past(ctl.sck)) && (o_prom_data_oe == $past(ctl.dir))
  ) else $error("software pin control not followed");

  chk_sw_access_off: assert property (
    (state == scfg_pkg::ST_IDLE && !ctl.en) |=> !o_prom_chip_select_pin && !o_prom_data_oe
  ) else $error("prom pins driven without software access");

  chk_data_in_status: assert property (
    (i_bus.rd && i_bus.addr == scfg_pkg::OFS_PROM_CTL)
      |=> (o_rdata[3] == $past(i_prom_data_pin)) && (o_rdata[5] == 1'b0)
  ) else $error("prom status bit not live pin level");

endmodule : scfg_top

`default_nettype wire

// File: bench/scfg_prom_model.sv
// scfg_prom_model: behavioural three-wire serial prom for the bench.
// assumes cs active high; data leaves after falling clock edges.
`timescale 1ns/1ps
`default_nettype none

module scfg_prom_model (
  input  wire logic        i_cs,
  input  wire logic        i_sk,
  input  wire logic        i_di,
  input  wire logic [47:0] i_words,
  output logic             o_drive,
  output logic             o_q,
  output logic [7:0]       o_frames,
  output logic             o_bad
);
  int          cnt = 0;
  logic [8:0]  hdr = '0;
  logic [15:0] word = '0;
  logic        sk_d = 1'b0;
  logic        drive = 1'b0;
  logic        q = 1'b0;
  logic [7:0]  frames = 8'h00;
  logic        bad = 1'b0;

  assign o_drive  = drive;
  assign o_q      = q;
  assign o_frames = frames;
  assign o_bad    = bad;

  // one process so each wire has a single writer; deselect frees the line at once
  always @(i_cs or i_sk) begin
    if (!i_cs) begin
      cnt = 0;
      drive = 1'b0;
    end else if (i_sk && !sk_d) begin
      if (cnt < 9) hdr = {hdr[7:0], i_di};
      cnt = cnt + 1;
      if (cnt == 9) begin
        bad = bad | (hdr[8:6] !== 3'b110);
        if (hdr[5:0] >= 6'h01 && hdr[5:0] <= 6'h03) word = i_words[16 * (hdr[5:0] - 1) +: 16];
        else word = {10'h000, ~hdr[5:0]};
        drive = 1'b1;
        q = 1'b0;
        frames = frames + 8'h01;
      end
    end else if (!i_sk && sk_d) begin
      // dummy zero first, then msb first; released once the word is out
      if (cnt >= 10 && cnt <= 25) q = word[25 - cnt];
      else if (cnt > 25) drive = 1'b0;
    end
    sk_d = i_sk;
  end
endmodule : scfg_prom_model

`default_nettype wire

// File: bench/tb_top.sv
// tb_top: self-checking bench for scfg_top with a serial prom model.
// assumes one 100 MHz clock and a pull on the prom data and clock wires.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic                    i_clock = 1'b0;
  logic                    i_rst = 1'b1;
  scfg_pkg::scfg_bus_req_t i_bus = '0;
  logic [15:0]             o_rdata;
  logic                    led = 1'b0;
  logic                    shared = 1'b0;
  logic                    pkg48 = 1'b0;
  logic                    pull_d = 1'b1;
  logic                    pull_k = 1'b0;
  logic                    dout, doe, skout, skoe, cs, busy, drv16;
  logic [1:0]              div;
  logic                    prom_drv, prom_q, bad;
  logic [7:0]              frames;
  logic [47:0]             words = '0;
  logic [15:0]             lfsr = 16'h0050;
  int                      fail_count = 0;
  int                      compares = 0;
  wire logic               d_wire;
  wire logic               k_wire;

  assign d_wire = doe ? dout : (prom_drv ? prom_q : pull_d);
  assign k_wire = skoe ? skout : pull_k;

  scfg_top scfg_top_inst (
    .i_clock                 (i_clock),
    .i_rst                   (i_rst),
    .i_bus                   (i_bus),
    .o_rdata                 (o_rdata),
    .i_port_led_strap_pin    (led),
    .i_shared_bus_strap      (shared),
    .i_package_48pin_bond    (pkg48),
    .i_prom_data_pin         (d_wire),
    .o_prom_data_pin         (dout),
    .o_prom_data_oe          (doe),
    .i_prom_serial_clock_pin (k_wire),
    .o_prom_serial_clock_pin (skout),
    .o_prom_serial_clock_oe  (skoe),
    .o_prom_chip_select_pin  (cs),
    .o_autoload_busy         (busy),
    .o_drive_strength_16ma   (drv16),
    .o_bus_clock_div         (div)
  );
  scfg_prom_model scfg_prom_model_inst (
    .i_cs     (cs),
    .i_sk     (k_wire),
    .i_di     (d_wire),
    .i_words  (words),
    .o_drive  (prom_drv),
    .o_q      (prom_q),
    .o_frames (frames),
    .o_bad    (bad)
  );

  always #5 i_clock = ~i_clock;

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd

  task automatic wrap_up();
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clock);
    i_bus.wr <= 1'b0;
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [15:0] e, input string nm);
    @(posedge i_clock);
    i_bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_clock);
    i_bus.rd <= 1'b0;
    #1 chk(nm, o_rdata, e);
  endtask : rc

  task automatic wait_busy(input logic lvl, input int lim);
    // look just after the edge so the flop has settled
    for (int n = 0; n < lim && busy !== lvl; n++) begin
      @(posedge i_clock);
      #1;
    end
    chk("busy", {15'h0000, busy}, {15'h0000, lvl});
    if (busy !== lvl) wrap_up();
  endtask : wait_busy

  task automatic boot(input logic prom);
    logic [15:0] r, v, e;
    logic [7:0]  f0;
    logic        b3;
    r = rnd();
    v = rnd();
    @(posedge i_clock);
    i_rst <= 1'b1;
    {led, shared, pkg48, pull_k} <= r[3:0];
    pull_d <= prom;
    words <= {r ^ v, v, r};
    repeat (8) @(posedge i_clock);
    chk("pins in reset", {13'h0000, cs, skoe, doe}, 16'h0000);
    f0 = frames;
    i_rst <= 1'b0;
    if (prom) begin
      wait_busy(1'b1, 10);
      wait_busy(1'b0, 6000);
    end else begin
      repeat (20) @(posedge i_clock);
      #1 chk("busy idle", {15'h0000, busy}, 16'h0000);
    end
    chk("frames", {8'h00, frames - f0}, prom ? 16'h0003 : 16'h0000);
    chk("pins freed", {13'h0000, bad, doe, cs}, 16'h0000);
    chk("clock pin driven", {15'h0000, skoe}, 16'h0001);
    e = '0;
    e[scfg_pkg::CFG_ENDIAN_BIT] = r[0];
    e[scfg_pkg::CFG_PROM_BIT] = prom;
    e[scfg_pkg::CFG_BUS8_BIT] = r[3];
    e[scfg_pkg::CFG_BUS16_BIT] = ~r[3];
    e[scfg_pkg::CFG_SHARED_BIT] = r[2];
    e[scfg_pkg::CFG_PKG48_BIT] = r[1];
    rc(scfg_pkg::OFS_STRAP_CFG, e, "config");
    wr(scfg_pkg::OFS_STRAP_CFG, ~e);
    rc(scfg_pkg::OFS_STRAP_CFG, e, "config ro");
    rc(8'h16, 16'h0000, "unmapped");
    rc(scfg_pkg::OFS_BUS_CLK, scfg_pkg::BUSCTL_RESET, "busctl reset");
    rc(scfg_pkg::OFS_PROM_CTL, {12'h000, pull_d, 3'h0}, "promctl reset");
    for (int i = 0; i < 3; i++) begin
      rc(scfg_pkg::OFS_ADDR_LOW + 8'(2 * i),
         prom ? words[16 * i +: 16] : scfg_pkg::STATION_RESET, "station");
      v = rnd();
      wr(scfg_pkg::OFS_ADDR_LOW + 8'(2 * i), v);
      rc(scfg_pkg::OFS_ADDR_LOW + 8'(2 * i), v, "station rw");
      chk("no prom write", {15'h0000, cs}, 16'h0000);
    end
    for (int k = 0; k < 4; k++) begin
      v = rnd();
      v[2:0] = {1'b0, 2'(k % 3)};
      wr(scfg_pkg::OFS_BUS_CLK, v);
      rc(scfg_pkg::OFS_BUS_CLK, v, "busctl");
      chk("bus outs", {13'h0000, drv16, div}, {13'h0000, v[6], 2'(k % 3)});
    end
    // software owns the pin timing here, one register write per edge
    for (int n = 0; n < 64; n++) begin
      v = 16'(n);
      wr(scfg_pkg::OFS_PROM_CTL, v);
      @(posedge i_clock);
      #1 chk("sw pins", {12'h000, cs, skout, doe, doe & dout},
             v[4] ? {12'h000, v[0], v[1], v[5], v[5] & v[2]} : 16'h0000);
      b3 = (v[4] & v[5]) ? v[2] : pull_d;
      rc(scfg_pkg::OFS_PROM_CTL, (v & 16'h0017) | {12'h000, b3, 3'h0}, "promctl");
    end
  endtask : boot

  initial begin
    boot(1'b1);
    boot(1'b0);
    // a short reset restarts auto-load; the reset in the next boot lands in the middle of its first frame
    @(posedge i_clock);
    i_rst <= 1'b1;
    pull_d <= 1'b1;
    @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (400) @(posedge i_clock);
    boot(1'b1);
    wrap_up();
  end
endmodule : tb_top

`default_nettype wire
